// File: hdl/vpf_drift.v
// vpf_drift: compares pixel strobe counts of successive windows
// assumes strobe marks one incoming pixel per cycle at most
`timescale 1ns/10ps
`default_nettype none
`include "vpf_defs.vh"
module vpf_drift (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire enable,
    input wire clr,
    input wire strobe,
    // result
    output reg err
);
    reg [7:0] tick;
    reg [8:0] cur;
    reg [8:0] prev;
    reg primed;
    wire [8:0] total = cur + {8'h0, strobe};
    wire [8:0] diff = (total > prev) ? total - prev : prev - total;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 8'h0;
            cur <= 9'h0;
            prev <= 9'h0;
            primed <= 1'b0;
            err <= 1'b0;
        end else if (!enable || clr) begin
            tick <= 8'h0;
            cur <= 9'h0;
            primed <= 1'b0;
            err <= 1'b0;
        end else begin
            tick <= tick + 8'h1;
            err <= 1'b0;
            if (tick == `VPF_DRIFT_LAST) begin
                // an idle first window never flags
                err <= primed && prev != 9'h0 && diff > `VPF_DRIFT_TOL;
                prev <= total;
                cur <= 9'h0;
                primed <= 1'b1;
            end else begin
                cur <= total;
            end
        end
    end
endmodule // vpf_drift
`default_nettype wire

// File: hdl/vpf_pack.v
// vpf_pack: doubles or triples pixels into one wider pipe pixel
// assumes one pixel per in_valid, low bits first on the wire
`timescale 1ns/10ps
`default_nettype none
`include "vpf_defs.vh"
module vpf_pack (
    // clock and reset
    input wire pclk,
    input wire presetn,
    input wire clr,
    // packing controls
    input wire dbl8,
    input wire dbl10,
    input wire dbl12,
    input wire utrip,
    // pixel in
    input wire in_valid,
    input wire in_line_end,
    input wire [23:0] in_data,
    input wire [5:0] in_dt,
    input wire [1:0] in_vc,
    input wire [5:0] in_width,
    // pixel out
    output reg out_valid,
    output reg [23:0] out_data,
    output reg [5:0] out_dt,
    output reg [1:0] out_vc,
    output reg [5:0] out_width,
    output reg flushed
);
    function is_user;
        input [5:0] dt;
        begin
            is_user = (dt == `VPF_UT_GEN) || (dt >= `VPF_UT_LO && dt <= `VPF_UT_HI) ||
                      (dt == `VPF_UT_E0) || (dt == `VPF_UT_E1);
        end
    endfunction
    reg [23:0] acc;
    reg [1:0] cnt;
    // double only for 8, 10, 12
    wire dbl = (in_width == 6'h08 && dbl8) || (in_width == 6'h0a && dbl10) ||
               (in_width == 6'h0c && dbl12);
    wire trip = utrip && in_width == 6'h08 && is_user(in_dt);
    wire [1:0] need = trip ? 2'h3 : (dbl ? 2'h2 : 2'h1);
    wire [5:0] sh = in_width * {4'h0, cnt};
    wire [23:0] pix = in_data & ~(24'hffffff << in_width);
    wire [23:0] merged = acc | (pix << sh);
    wire last = (cnt + 2'h1) == need;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 24'h0;
            cnt <= 2'h0;
            out_valid <= 1'b0;
            out_data <= 24'h0;
            out_dt <= 6'h0;
            out_vc <= 2'h0;
            out_width <= 6'h0;
            flushed <= 1'b0;
        end else if (clr) begin
            acc <= 24'h0;
            cnt <= 2'h0;
            out_valid <= 1'b0;
            flushed <= 1'b0;
        end else begin
            out_valid <= in_valid && last;
            flushed <= 1'b0;
            if (in_valid && last) begin
                out_data <= merged;
                out_dt <= in_dt;
                out_vc <= in_vc;
                out_width <= in_width * {4'h0, need};
                acc <= 24'h0;
                cnt <= 2'h0;
            end else if (in_line_end && (in_valid || cnt != 2'h0)) begin
                // partial pair or triple at line end cannot be sent, dropped
                flushed <= 1'b1;
                acc <= 24'h0;
                cnt <= 2'h0;
            end else if (in_valid) begin
                acc <= merged;
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // vpf_pack
`default_nettype wire

// File: hdl/vpf_top.v
// vpf_top: pixel format stage of one video pipe with apb registers
// assumes receiver and packetizer logic run on pclk, no stalls
// Summary of operation
// - type override enable swaps pipe data type for programmed type
// - channel override enable swaps virtual channel for 2-bit field
// - width override enable replaces received pixel width
// - double mode joins two 8, 10 or 12 bit pixels
// - 8-bit doubling bit sends 8-bit pixels as 16
// - 10-bit to 20 and 12-bit to 24 doubling bits
// - user type bit packs three 8-bit user pixels into 24
// - pixels may be zero padded up to 16 bits
// - padding after doubling, widths between 8 and 16
// - padded pipe runs at largest width, items take forced width
// - narrower items padded with zeros to forced width
// - width source bit picks receiver or forced width
// - forced width used only with automatic selection off
// - drift check resets the pipe on error and reports it
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "vpf_defs.vh"
module vpf_top (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pixels from the receiver
    input wire in_valid,
    input wire in_line_end,
    input wire [23:0] in_data,
    input wire [5:0] in_dt,
    input wire [1:0] in_vc,
    input wire [5:0] in_width,
    // pixels to the packetizer
    output reg out_valid,
    output reg [23:0] out_data,
    output reg [5:0] out_dt,
    output reg [1:0] out_vc,
    output reg [5:0] out_width,
    // pipe reset and interrupt
    output reg pipe_reset,
    output reg irq
);
    function [23:0] wmask;
        input [5:0] w;
        begin
            wmask = ~(24'hffffff << w);
        end
    endfunction

    // registers
    reg [7:0] pipe_width_source_ctrl;
    reg [7:0] pipe_forced_width;
    reg [7:0] pipe_drift_ctrl;
    reg [7:0] eight_bit_double_ctrl;
    reg [7:0] ten_twelve_double_ctrl;
    reg [7:0] header_override_ctrl;
    reg [7:0] channel_override_value;
    reg [7:0] type_override_value;
    reg [7:0] user_type_width_ctrl;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [7:0] drift_count;

    // named controls
    // doubling, triple, drift and width controls
    wire eight_bit_double_enable = eight_bit_double_ctrl[`VPF_D8_BIT];
    wire ten_bit_double_enable = ten_twelve_double_ctrl[`VPF_D10_BIT];
    wire twelve_bit_double_enable = ten_twelve_double_ctrl[`VPF_D12_BIT];
    wire user_type_triple_enable = user_type_width_ctrl[`VPF_UTRIP_BIT];
    wire clock_drift_check_enable = pipe_drift_ctrl[`VPF_DRIFT_EN];
    wire auto_width = pipe_width_source_ctrl[`VPF_WSRC_AUTO];
    wire [5:0] forced_w = pipe_forced_width[`VPF_FWID_F];

    // apb decode
    wire [9:0] idx = paddr[11:2];
    reg hit;
    reg [7:0] rd_mux;
    wire acc_phase = psel && penable && !pready;
    wire wr_go = psel && penable && pready && pwrite && pstrb[0] && hit;
    wire rd_only = (idx == `VPF_IDX_PSTAT) || (idx == `VPF_IDX_ECNT);
    wire [7:0] wd = pwdata[7:0];

    // packer and drift outputs
    wire pk_valid;
    wire [23:0] pk_data;
    wire [5:0] pk_dt;
    wire [1:0] pk_vc;
    wire [5:0] pk_width;
    wire pk_flushed;
    wire drift_err;

    // pipe attributes
    wire [5:0] ov_width;
    wire [5:0] pipe_w;
    wire pad_on;
    wire [23:0] padded;
    wire [7:0] next_status;
    wire [7:0] ev;

    always @* begin
        hit = 1'b1;
        rd_mux = 8'h00;
        case (idx)
            `VPF_IDX_WSRC: rd_mux = pipe_width_source_ctrl;
            `VPF_IDX_FWID: rd_mux = pipe_forced_width;
            `VPF_IDX_DRIFT: rd_mux = pipe_drift_ctrl;
            `VPF_IDX_D8: rd_mux = eight_bit_double_ctrl;
            `VPF_IDX_D1012: rd_mux = ten_twelve_double_ctrl;
            `VPF_IDX_HOV: rd_mux = header_override_ctrl;
            `VPF_IDX_VCV: rd_mux = channel_override_value;
            `VPF_IDX_DTV: rd_mux = type_override_value;
            `VPF_IDX_UTRIP: rd_mux = user_type_width_ctrl;
            `VPF_IDX_ISTAT: rd_mux = irq_status;
            `VPF_IDX_IMASK: rd_mux = irq_mask;
            `VPF_IDX_PSTAT: rd_mux = {pad_on, 1'b0, pipe_w};
            `VPF_IDX_ECNT: rd_mux = drift_count;
            default: hit = 1'b0;
        endcase
    end

    // one wait state: pready rises on the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc_phase;
            pslverr <= acc_phase && (!hit || (pwrite && rd_only));
            if (acc_phase && !pwrite) begin
                prdata <= {24'h0, rd_mux};
            end
        end
    end

    // configuration writes, lane 0 only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_width_source_ctrl <= `VPF_RST_WSRC;
            pipe_forced_width <= `VPF_RST_FWID;
            pipe_drift_ctrl <= `VPF_RST_DRIFT;
            eight_bit_double_ctrl <= `VPF_RST_ZERO;
            ten_twelve_double_ctrl <= `VPF_RST_ZERO;
            header_override_ctrl <= `VPF_RST_HOV;
            channel_override_value <= `VPF_RST_ZERO;
            type_override_value <= `VPF_RST_DTV;
            user_type_width_ctrl <= `VPF_RST_ZERO;
            irq_mask <= `VPF_RST_ZERO;
        end else if (wr_go) begin
            case (idx)
                `VPF_IDX_WSRC: pipe_width_source_ctrl <= wd;
                `VPF_IDX_FWID: pipe_forced_width <= wd;
                `VPF_IDX_DRIFT: pipe_drift_ctrl <= wd;
                `VPF_IDX_D8: eight_bit_double_ctrl <= wd;
                `VPF_IDX_D1012: ten_twelve_double_ctrl <= wd;
                `VPF_IDX_HOV: header_override_ctrl <= wd;
                `VPF_IDX_VCV: channel_override_value <= wd;
                `VPF_IDX_DTV: type_override_value <= wd;
                `VPF_IDX_UTRIP: user_type_width_ctrl <= wd;
                `VPF_IDX_IMASK: irq_mask <= wd;
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    vpf_pack u_pack (
        .pclk(pclk),
        .presetn(presetn),
        .clr(pipe_reset),
        .dbl8(eight_bit_double_enable),
        .dbl10(ten_bit_double_enable),
        .dbl12(twelve_bit_double_enable),
        .utrip(user_type_triple_enable),
        .in_valid(in_valid),
        .in_line_end(in_line_end),
        .in_data(in_data),
        .in_dt(in_dt),
        .in_vc(in_vc),
        .in_width(in_width),
        .out_valid(pk_valid),
        .out_data(pk_data),
        .out_dt(pk_dt),
        .out_vc(pk_vc),
        .out_width(pk_width),
        .flushed(pk_flushed)
    );

    // drift check on incoming pixel rate
    vpf_drift u_drift (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clock_drift_check_enable),
        .clr(pipe_reset),
        .strobe(in_valid),
        .err(drift_err)
    );

    assign ov_width = header_override_ctrl[`VPF_HOV_WEN] ?
                      {1'b0, header_override_ctrl[`VPF_HOV_W]} : pk_width;
    assign pipe_w = auto_width ? ov_width : forced_w;
    // padding only for 8..16 after doubling
    assign pad_on = !auto_width && forced_w >= `VPF_PAD_MIN && forced_w <= `VPF_PAD_MAX;
    // zeros above item width up to forced width
    assign padded = pk_data & wmask(pk_width) & wmask(forced_w);

    // interrupt events
    assign ev = {6'h0, pk_flushed, drift_err};
    assign next_status = (irq_status & ~((wr_go && idx == `VPF_IDX_ISTAT) ? wd : 8'h00)) | ev;

    // output stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= 24'h0;
            out_dt <= 6'h0;
            out_vc <= 2'h0;
            out_width <= 6'h0;
        end else if (pipe_reset) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= pk_valid;
            if (pk_valid) begin
                out_data <= pad_on ? padded : pk_data;
                out_dt <= header_override_ctrl[`VPF_HOV_DT] ?
                          type_override_value[`VPF_DTV_F] : pk_dt;
                out_vc <= header_override_ctrl[`VPF_HOV_VC] ?
                          channel_override_value[`VPF_VCV_F] : pk_vc;
                out_width <= pipe_w;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_reset <= 1'b0;
            irq_status <= 8'h00;
            irq <= 1'b0;
            drift_count <= 8'h00;
        end else begin
            pipe_reset <= drift_err;
            // set wins over a clear in the same cycle
            irq_status <= next_status;
            irq <= |(next_status & irq_mask);
            if (drift_err && drift_count != 8'hff) begin
                drift_count <= drift_count + 8'h01;
            end
        end
    end
endmodule // vpf_top
`default_nettype wire

// File: inc/vpf_defs.vh
// vpf_defs.vh: register indices, fields, reset values and counts
// for the pixel format stage; byte address is four times the index
`ifndef VPF_DEFS_VH
`define VPF_DEFS_VH
// register indices
`define VPF_IDX_WSRC 10'h110
`define VPF_IDX_FWID 10'h111
`define VPF_IDX_DRIFT 10'h112
`define VPF_IDX_D8 10'h312
`define VPF_IDX_D1012 10'h313
`define VPF_IDX_HOV 10'h31e
`define VPF_IDX_VCV 10'h320
`define VPF_IDX_DTV 10'h323
`define VPF_IDX_UTRIP 10'h337
`define VPF_IDX_ISTAT 10'h340
`define VPF_IDX_IMASK 10'h341
`define VPF_IDX_PSTAT 10'h342
`define VPF_IDX_ECNT 10'h343
// fields
`define VPF_WSRC_AUTO 3
`define VPF_FWID_F 5:0
`define VPF_DRIFT_EN 1
`define VPF_D8_BIT 2
`define VPF_D10_BIT 2
`define VPF_D12_BIT 6
`define VPF_HOV_DT 7
`define VPF_HOV_VC 6
`define VPF_HOV_WEN 5
`define VPF_HOV_W 4:0
`define VPF_VCV_F 5:4
`define VPF_DTV_F 5:0
`define VPF_UTRIP_BIT 5
`define VPF_IRQ_DRIFT 0
`define VPF_IRQ_FLUSH 1
// reset values
`define VPF_RST_WSRC 8'h08
`define VPF_RST_FWID 8'h18
`define VPF_RST_DRIFT 8'h02
`define VPF_RST_HOV 8'h18
`define VPF_RST_DTV 8'h30
`define VPF_RST_ZERO 8'h00
// user defined type header codes
`define VPF_UT_GEN 6'h30
`define VPF_UT_LO 6'h31
`define VPF_UT_HI 6'h37
`define VPF_UT_E0 6'h10
`define VPF_UT_E1 6'h11
// padding limits
`define VPF_PAD_MIN 6'h08
`define VPF_PAD_MAX 6'h10
// drift check: window of 256 cycles, tolerance in strobes
`define VPF_DRIFT_LAST 8'hff
`define VPF_DRIFT_TOL 9'h004
`endif

// File: verification/vpf_props.sv
// vpf_props: checker bound to vpf_top
// assumes registers change only while no pixel is in flight
`timescale 1ns/10ps
`default_nettype none
`include "vpf_defs.vh"
module vpf_props (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // pixels
    input wire logic in_valid,
    input wire logic [5:0] in_dt,
    input wire logic out_valid,
    input wire logic [23:0] out_data,
    input wire logic [5:0] out_dt,
    input wire logic [1:0] out_vc,
    input wire logic [5:0] out_width,
    input wire logic pipe_reset
);
    logic [7:0] wsrc, fwid, hov, vcv, dtv;
    wire logic wr = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow copy, updated at the edge a write lands
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wsrc <= 8'h08;
            fwid <= 8'h18;
            hov <= 8'h18;
            vcv <= 8'h00;
            dtv <= 8'h30;
        end else if (wr) begin
            case (paddr[11:2])
                `VPF_IDX_WSRC: wsrc <= pwdata[7:0];
                `VPF_IDX_FWID: fwid <= pwdata[7:0];
                `VPF_IDX_HOV: hov <= pwdata[7:0];
                `VPF_IDX_VCV: vcv <= pwdata[7:0];
                `VPF_IDX_DTV: dtv <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    property p_dt_ovr;
        out_valid && hov[7] |-> out_dt == dtv[5:0];
    endproperty
    a_dt_ovr: assert property (p_dt_ovr) else $error("type override");
    property p_vc_ovr;
        out_valid && hov[6] |-> out_vc == vcv[5:4];
    endproperty
    a_vc_ovr: assert property (p_vc_ovr) else $error("channel override");
    property p_w_ovr;
        out_valid && hov[5] && wsrc[3] |-> out_width == {1'b0, hov[4:0]};
    endproperty
    a_w_ovr: assert property (p_w_ovr) else $error("width override");
    property p_lat;
        out_valid |-> $past(in_valid, 2);
    endproperty
    a_lat: assert property (p_lat) else $error("output without input");
    property p_dt_pass;
        out_valid && !hov[7] |-> out_dt == $past(in_dt, 2);
    endproperty
    a_dt_pass: assert property (p_dt_pass) else $error("type altered");
    property p_fwid;
        out_valid && !wsrc[3] |-> out_width == fwid[5:0];
    endproperty
    a_fwid: assert property (p_fwid) else $error("forced width");
    property p_pad;
        out_valid && !wsrc[3] && fwid[5:0] >= 6'd8 && fwid[5:0] <= 6'd16
            |-> (out_data >> fwid[5:0]) == 24'h0;
    endproperty
    a_pad: assert property (p_pad) else $error("padding not zero");
    property p_rst;
        pipe_reset |=> !pipe_reset ##1 !pipe_reset;
    endproperty
    a_rst: assert property (p_rst) else $error("pipe reset too long");
    c_dbl: cover property (out_valid && out_width == 6'd20);
    c_pad: cover property (out_valid && !wsrc[3]);
    c_rst: cover property (pipe_reset);
endmodule // vpf_props
bind vpf_top vpf_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .in_valid(in_valid), .in_dt(in_dt),
    .out_valid(out_valid), .out_data(out_data), .out_dt(out_dt), .out_vc(out_vc),
    .out_width(out_width), .pipe_reset(pipe_reset));
`default_nettype wire

// File: verification/vpf_src_model.sv
// vpf_src_model: receiver side pixel source
// assumes the bench calls send; one pixel per cycle at most
`timescale 1ns/10ps
`default_nettype none
module vpf_src_model (
    // clock
    input wire logic pclk,
    // pixels toward the block
    output logic in_valid,
    output logic in_line_end,
    output logic [23:0] in_data,
    output logic [5:0] in_dt,
    output logic [1:0] in_vc,
    output logic [5:0] in_width
);
    initial begin
        in_valid = 1'b0;
        in_line_end = 1'b0;
        in_data = 24'h0;
        in_dt = 6'h0;
        in_vc = 2'h0;
        in_width = 6'h8;
    end
    // idle data inverts so a stale pixel is never reused
    task send(input int n, input logic [5:0] dt, input logic [1:0] vc,
              input logic [5:0] w, input logic [23:0] d0, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            in_valid <= 1'b1;
            in_line_end <= (i == n - 1);
            in_data <= d0 + 24'(i);
            in_dt <= dt;
            in_vc <= vc;
            in_width <= w;
            repeat (gap) begin
                @(posedge pclk);
                in_valid <= 1'b0;
                in_line_end <= 1'b0;
                in_data <= ~in_data;
            end
        end
        @(posedge pclk);
        in_valid <= 1'b0;
        in_line_end <= 1'b0;
        in_data <= ~in_data;
    endtask
endmodule // vpf_src_model
`default_nettype wire

// File: verification/vpf_tb_top.sv
// vpf_tb_top: directed bench for vpf_top over apb
// assumes vpf_props binds itself and vpf_src_model feeds pixels
`timescale 1ns/10ps
`default_nettype none
`include "vpf_defs.vh"
module video_pipe_pixel_format_override_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
    logic in_valid, in_line_end, out_valid, pipe_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [23:0] in_data, out_data, o_data;
    logic [5:0] in_dt, in_width, out_dt, out_width, o_dt, o_w;
    logic [1:0] in_vc, out_vc, o_vc;
    logic [7:0] rd;
    int error_cnt, num_checks, n_out, n_rst, cyc, r0;
    logic [9:0] ri [9] = '{10'h110, 10'h111, 10'h112, 10'h31e, 10'h323, 10'h312,
        10'h313, 10'h320, 10'h337};
    logic [7:0] rv [9] = '{8'h08, 8'h18, 8'h02, 8'h18, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [9:0] dr [3] = '{10'h312, 10'h313, 10'h313};
    logic [7:0] dv [3] = '{8'h04, 8'h04, 8'h40};
    logic [5:0] dw [3] = '{6'd8, 6'd10, 6'd12};
    logic [5:0] ut [5] = '{6'h30, 6'h31, 6'h37, 6'h10, 6'h11};
    vpf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_line_end(in_line_end), .in_data(in_data), .in_dt(in_dt), .in_vc(in_vc),
        .in_width(in_width), .out_valid(out_valid), .out_data(out_data),
        .out_dt(out_dt), .out_vc(out_vc), .out_width(out_width),
        .pipe_reset(pipe_reset), .irq(irq));
    vpf_src_model SRC (.pclk(pclk), .in_valid(in_valid), .in_line_end(in_line_end),
        .in_data(in_data), .in_dt(in_dt), .in_vc(in_vc), .in_width(in_width));
    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string s, input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task run(input int n, input logic [5:0] dt, input logic [1:0] vc, input logic [5:0] w,
             input logic [23:0] d0, input int gap, input int eo, input logic [23:0] ed,
             input logic [5:0] edt, input logic [1:0] evc, input logic [5:0] ew);
        int n0;
        n0 = n_out;
        SRC.send(n, dt, vc, w, d0, gap);
        repeat (4) @(posedge pclk);
        chk("pixel count", 24'(n_out - n0), 24'(eo));
        if (eo > 0) begin
            chk("data", o_data, ed);
            chk("type", 24'(o_dt), 24'(edt));
            chk("channel", 24'(o_vc), 24'(evc));
            chk("width", 24'(o_w), 24'(ew));
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // output monitor and hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1) begin
            n_out <= n_out + 1;
            o_data <= out_data;
            o_dt <= out_dt;
            o_vc <= out_vc;
            o_w <= out_width;
        end
        if (pipe_reset === 1'b1) n_rst <= n_rst + 1;
        if (cyc == 12000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        {error_cnt, num_checks, n_out, n_rst, cyc} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ri[k]) begin
            apb(1'b0, ri[k], 8'h00);
            chk("reset value", 24'(rd), 24'(rv[k]));
        end
        apb(1'b0, 10'h000, 8'h00);
        chk("unmapped error", 24'(er), 24'h1);
        pstrb <= 4'h0;
        apb(1'b1, `VPF_IDX_FWID, 8'h3f);
        chk("strobe no error", 24'(er), 24'h0);
        pstrb <= 4'hf;
        apb(1'b0, `VPF_IDX_FWID, 8'h00);
        chk("strobe ignored", 24'(rd), 24'h000018);
        apb(1'b1, `VPF_IDX_DRIFT, 8'h00);
        $display("test registers done");
        run(1, 6'h2c, 2'd1, 6'd12, 24'h000123, 0, 1, 24'h000123, 6'h2c, 2'd1, 6'd12);
        apb(1'b1, `VPF_IDX_DTV, 8'h24);
        apb(1'b1, `VPF_IDX_VCV, 8'h30);
        apb(1'b1, `VPF_IDX_HOV, 8'hee);
        run(1, 6'h2c, 2'd1, 6'd12, 24'h000123, 0, 1, 24'h000123, 6'h24, 2'd3, 6'd14);
        apb(1'b1, `VPF_IDX_HOV, 8'h18);
        $display("test override done");
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, dr[k], dv[k]);
            apb(1'b1, `VPF_IDX_HOV, 8'h20 | 8'(2 * dw[k]));
            run(2, 6'h2a, 2'd0, dw[k], 24'h0000a5, 0, 1, 24'h0000a5 | (24'h0000a6 << dw[k]),
                6'h2a, 2'd0, 6'(2 * dw[k]));
            apb(1'b1, dr[k], 8'h00);
        end
        $display("test double done");
        apb(1'b1, `VPF_IDX_UTRIP, 8'h20);
        apb(1'b1, `VPF_IDX_HOV, 8'h38);
        foreach (ut[k]) begin
            run(3, ut[k], 2'd0, 6'd8, 24'h000031, 1, 1, 24'h333231, ut[k], 2'd0, 6'd24);
        end
        apb(1'b1, `VPF_IDX_UTRIP, 8'h00);
        $display("test triple done");
        apb(1'b1, `VPF_IDX_WSRC, 8'h00);
        apb(1'b1, `VPF_IDX_FWID, 8'h10);
        apb(1'b1, `VPF_IDX_HOV, 8'h2c);
        run(1, 6'h2c, 2'd0, 6'd12, 24'hfabfff, 0, 1, 24'h000fff, 6'h2c, 2'd0, 6'd16);
        apb(1'b0, `VPF_IDX_PSTAT, 8'h00);
        chk("pipe status", 24'(rd), 24'h000090);
        apb(1'b1, `VPF_IDX_WSRC, 8'h08);
        apb(1'b1, `VPF_IDX_FWID, 8'h18);
        $display("test padding done");
        apb(1'b1, `VPF_IDX_D8, 8'h04);
        apb(1'b1, `VPF_IDX_HOV, 8'h30);
        apb(1'b1, `VPF_IDX_IMASK, 8'h02);
        run(1, 6'h12, 2'd0, 6'd8, 24'h00005a, 0, 0, 24'h0, 6'h0, 2'd0, 6'd0);
        chk("irq raised", 24'(irq), 24'h1);
        apb(1'b1, `VPF_IDX_IMASK, 8'h00);
        repeat (2) @(posedge pclk);
        chk("irq masked", 24'(irq), 24'h0);
        apb(1'b1, `VPF_IDX_IMASK, 8'h03);
        apb(1'b1, `VPF_IDX_ISTAT, 8'h02);
        apb(1'b1, `VPF_IDX_D8, 8'h00);
        apb(1'b1, `VPF_IDX_HOV, 8'h18);
        chk("irq cleared", 24'(irq), 24'h0);
        $display("test line end done");
        apb(1'b1, `VPF_IDX_DRIFT, 8'h02);
        r0 = n_rst;
        SRC.send(400, 6'h2c, 2'd0, 6'd12, 24'h000100, 0);
        for (int t = 0; t < 1000 && n_rst == r0; t++) @(posedge pclk);
        chk("pipe reset", 24'(n_rst > r0), 24'h1);
        apb(1'b0, `VPF_IDX_ISTAT, 8'h00);
        chk("drift status", 24'(rd), 24'h000001);
        chk("drift irq", 24'(irq), 24'h1);
        apb(1'b1, `VPF_IDX_ECNT, 8'h00);
        chk("read only error", 24'(er), 24'h1);
        apb(1'b0, `VPF_IDX_ECNT, 8'h00);
        chk("drift count", 24'(rd), 24'h000001);
        $display("test drift done");
        end_of_test();
    end
endmodule // video_pipe_pixel_format_override_tb_top
`default_nettype wire
